// ### hw/scprb_pkg.sv
// Constants, field layout and carrier types for the serial control port.
// Assumes a 7-bit register address space with 9-bit register data.

package scprb_pkg;

  // Word layout
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 9;
  localparam int WORD_W   = ADDR_W + DATA_W;
  localparam int STAT_W   = 8;
  localparam int NSTAT    = 7;

  // Register addresses
  localparam logic [6:0] RB_CTRL_ADDR   = 7'h34;
  localparam logic [6:0] SW_RESET_ADDR  = 7'h35;
  localparam logic [6:0] STAT_BASE_ADDR = 7'h38;

  // Read-back control fields
  localparam logic [8:0] RB_CTRL_RESET  = 9'h000;
  localparam int         SEL_LSB        = 0;
  localparam int         SEL_W          = 3;
  localparam int         CONT_BIT       = 3;
  localparam int         EN_BIT         = 4;

  // Status select codes
  localparam logic [2:0] SEL_ERROR      = 3'h0;
  localparam logic [2:0] SEL_CHAN_LAST  = 3'h5;
  localparam logic [2:0] SEL_SPDIF      = 3'h6;

  // 2-wire device address, upper six bits; low bit follows chip select
  localparam logic [5:0] DEV_ADDR_HI    = 6'h0d;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [3:0] RB_BITS        = 4'h8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scprb_wr_s;

  typedef logic [STAT_W-1:0] scprb_byte_t;

  typedef enum {
    TW_IDLE, TW_DEV, TW_ACK_DEV, TW_REG_HI, TW_ACK_HI,
    TW_REG_LO, TW_ACK_LO, TW_READ, TW_WAIT_STOP
  } scprb_tw_e;

endpackage

// ### hw/scprb_top.sv
// Serial control port front end with status read-back.
// Assumes a host drives serial clock, data and chip select; status bytes come
// from logic on MCLK_I; the register file sits outside and takes REG_WR_O.
//
// Overview of operation
// - Strap low selects software control
// - Bus strap low two-wire, high three-wire
// - Three-wire data captured on serial clock rise
// - Three-wire word: seven address, nine data
// - Chip select rising edge commits the word
// - Three-wire read-back only while enable bit set
// - Continuous mode: any write except to reset address returns selected status
// - Select field picks error, channel, S/PDIF status
// - Read-back output released unless chip select low
// - Direct mode: status address write returns it
// - Data fall with clock high starts transfer
// - Shift eight bits MSB first: address, direction
// - Matching address acknowledged by pulling data low
// - Mismatched address returns to idle
// - First byte: register address plus data MSB
// - Second byte: remaining eight data bits, acknowledged
// - Data rise with clock high ends transfer
// - Out-of-sequence start or stop abandons transfer
// - Chip select level picks two-wire address
// - Write to reset address restores defaults

`timescale 1ns/1ns
`default_nettype none

module scprb_top #(
  parameter int NUM_STATUS = scprb_pkg::NSTAT
) (
  // Clocks and reset
  input  wire logic                                   MCLK_I,
  input  wire logic                                   RESET_I,
  input  wire logic                                   SERIAL_CLK_I,
  // Straps
  input  wire logic                                   CONTROL_STYLE_STRAP_I,
  input  wire logic                                   BUS_STYLE_STRAP_I,
  // Serial pins
  input  wire logic                                   CHIP_SELECT_N_I,
  input  wire logic                                   SERIAL_DATA_PIN_I,
  output logic                                        SERIAL_DATA_PIN_O,
  output logic                                        SERIAL_DATA_PIN_OE_O,
  output logic                                        READBACK_OUT_PIN_O,
  output logic                                        READBACK_OUT_PIN_OE_O,
  // Status sources
  input  wire logic [NUM_STATUS-1:0][scprb_pkg::STAT_W-1:0] STATUS_I,
  // Register file side
  output logic                                        REG_WR_O,
  output scprb_pkg::scprb_wr_s                        REG_WR_WORD_O,
  output logic                                        SW_RESET_O,
  output logic                                        SW_CONTROL_O,
  output logic [scprb_pkg::DATA_W-1:0]                READBACK_CONTROL_O
);

  if (NUM_STATUS < 1 || NUM_STATUS > scprb_pkg::NSTAT) begin : g_bad_status
    $error("NUM_STATUS must lie between 1 and 7");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain shift register

  logic [scprb_pkg::WORD_W-1:0] link_sh;

  always_ff @(posedge SERIAL_CLK_I) begin
    if (!CHIP_SELECT_N_I) begin
      link_sh <= {link_sh[scprb_pkg::WORD_W-2:0], SERIAL_DATA_PIN_I};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: 0 cs, 1 clk, 2 data, 3 control strap, 4 bus strap

  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic       three_wire;

  always_ff @(posedge MCLK_I) begin
    sync1 <= {BUS_STYLE_STRAP_I, CONTROL_STYLE_STRAP_I, SERIAL_DATA_PIN_I,
              SERIAL_CLK_I, CHIP_SELECT_N_I};
    sync2 <= sync1;
    sync3 <= sync2;
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      SW_CONTROL_O <= 1'b0;
      three_wire   <= 1'b0;
    end else begin
      SW_CONTROL_O <= ~sync2[3];
      three_wire   <= sync2[4];
    end
  end

  logic csb_low;
  logic csb_rise;
  logic csb_fall;
  logic scl_rise;
  logic scl_fall;
  logic scl_high;
  logic sda;
  logic start_det;
  logic stop_det;
  logic two_wire;

  assign csb_low   = ~sync2[0];
  assign csb_rise  = sync2[0] & ~sync3[0];
  assign csb_fall  = ~sync2[0] & sync3[0];
  assign scl_rise  = sync2[1] & ~sync3[1];
  assign scl_fall  = ~sync2[1] & sync3[1];
  assign scl_high  = sync2[1] & sync3[1];
  assign sda       = sync2[2];
  assign start_det = scl_high & ~sync2[2] & sync3[2];
  assign stop_det  = scl_high & sync2[2] & ~sync3[2];
  assign two_wire  = SW_CONTROL_O & ~three_wire;

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire transfer engine

  scprb_pkg::scprb_tw_e st;
  logic [2:0]           bit_cnt;
  logic [7:0]           sh;
  logic [7:0]           hi_byte;
  logic [7:0]           rd_sh;
  logic                 rw;
  logic [7:0]           shift_in;
  logic [6:0]           dev_addr;
  logic                 i2c_wr;
  scprb_pkg::scprb_byte_t read_src;
  scprb_pkg::scprb_byte_t live_byte;
  scprb_pkg::scprb_byte_t rb_byte;
  logic [8:0]           ctrl;

  assign shift_in = {sh[6:0], sda};
  assign dev_addr = {scprb_pkg::DEV_ADDR_HI, sync2[0]};
  assign i2c_wr   = (st == scprb_pkg::TW_ACK_LO) && scl_fall && SERIAL_DATA_PIN_OE_O;
  assign read_src = ctrl[scprb_pkg::CONT_BIT] ? live_byte : rb_byte;

  always_ff @(posedge MCLK_I) begin
    SERIAL_DATA_PIN_O <= 1'b0;
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I || !two_wire) begin
      st                   <= scprb_pkg::TW_IDLE;
      bit_cnt              <= 3'h0;
      sh                   <= 8'h00;
      hi_byte              <= 8'h00;
      rd_sh                <= 8'h00;
      rw                   <= 1'b0;
      SERIAL_DATA_PIN_OE_O <= 1'b0;
    end else if (stop_det) begin
      st                   <= scprb_pkg::TW_IDLE;
      SERIAL_DATA_PIN_OE_O <= 1'b0;
    end else if (start_det) begin
      bit_cnt              <= 3'h0;
      SERIAL_DATA_PIN_OE_O <= 1'b0;
      if (st == scprb_pkg::TW_IDLE || st == scprb_pkg::TW_WAIT_STOP) begin
        st <= scprb_pkg::TW_DEV;
      end else begin
        st <= scprb_pkg::TW_IDLE;
      end
    end else begin
      unique case (st)
        scprb_pkg::TW_IDLE, scprb_pkg::TW_WAIT_STOP: begin
        end
        scprb_pkg::TW_DEV, scprb_pkg::TW_REG_HI, scprb_pkg::TW_REG_LO: begin
          if (scl_rise) begin
            sh      <= shift_in;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == scprb_pkg::BIT_LAST) begin
              if (st == scprb_pkg::TW_DEV) begin
                if (shift_in[7:1] == dev_addr) begin
                  rw <= shift_in[0];
                  st <= scprb_pkg::TW_ACK_DEV;
                end else begin
                  st <= scprb_pkg::TW_IDLE;
                end
              end else if (st == scprb_pkg::TW_REG_HI) begin
                hi_byte <= shift_in;
                st      <= scprb_pkg::TW_ACK_HI;
              end else begin
                st <= scprb_pkg::TW_ACK_LO;
              end
            end
          end
        end
        scprb_pkg::TW_ACK_DEV, scprb_pkg::TW_ACK_HI, scprb_pkg::TW_ACK_LO: begin
          if (scl_fall) begin
            if (!SERIAL_DATA_PIN_OE_O) begin
              SERIAL_DATA_PIN_OE_O <= 1'b1;
            end else begin
              SERIAL_DATA_PIN_OE_O <= 1'b0;
              bit_cnt              <= 3'h0;
              if (st == scprb_pkg::TW_ACK_DEV && rw) begin
                st                   <= scprb_pkg::TW_READ;
                SERIAL_DATA_PIN_OE_O <= ~read_src[7];
                rd_sh                <= {read_src[6:0], 1'b0};
              end else if (st == scprb_pkg::TW_ACK_DEV) begin
                st <= scprb_pkg::TW_REG_HI;
              end else if (st == scprb_pkg::TW_ACK_HI) begin
                st <= scprb_pkg::TW_REG_LO;
              end else begin
                st <= scprb_pkg::TW_WAIT_STOP;
              end
            end
          end
        end
        scprb_pkg::TW_READ: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == scprb_pkg::BIT_LAST) begin
              SERIAL_DATA_PIN_OE_O <= 1'b0;
              st                   <= scprb_pkg::TW_WAIT_STOP;
            end else begin
              SERIAL_DATA_PIN_OE_O <= ~rd_sh[7];
              rd_sh                <= {rd_sh[6:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write requests and read-back source selection

  logic                 tw3_wr;
  logic                 wr_req;
  scprb_pkg::scprb_wr_s wr_word;
  scprb_pkg::scprb_wr_s link_word;
  logic [6:0]           stat_idx;
  logic                 stat_hit;
  scprb_pkg::scprb_byte_t direct_byte;
  logic [2:0]           sel;
  logic                 rb_valid;

  assign link_word = link_sh;
  assign tw3_wr    = SW_CONTROL_O && three_wire && csb_rise;
  assign wr_req    = tw3_wr | i2c_wr;
  assign wr_word   = tw3_wr ? link_word :
                     scprb_pkg::scprb_wr_s'({hi_byte, sh});
  assign sel       = ctrl[scprb_pkg::SEL_LSB +: scprb_pkg::SEL_W];
  assign stat_idx  = wr_word.addr - scprb_pkg::STAT_BASE_ADDR;
  assign stat_hit  = (wr_word.addr >= scprb_pkg::STAT_BASE_ADDR) &&
                     (stat_idx < 7'(NUM_STATUS));

  always_comb begin
    live_byte = 8'h00;
    if (32'(sel) < NUM_STATUS) begin
      live_byte = STATUS_I[sel];
    end
  end

  always_comb begin
    direct_byte = 8'h00;
    if (stat_hit) begin
      direct_byte = STATUS_I[stat_idx];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ctrl          <= scprb_pkg::RB_CTRL_RESET;
      REG_WR_O      <= 1'b0;
      REG_WR_WORD_O <= '0;
      SW_RESET_O    <= 1'b0;
      rb_byte       <= 8'h00;
      rb_valid      <= 1'b0;
    end else begin
      REG_WR_O   <= wr_req;
      SW_RESET_O <= 1'b0;
      if (wr_req) begin
        REG_WR_WORD_O <= wr_word;
        if (wr_word.addr == scprb_pkg::SW_RESET_ADDR) begin
          ctrl       <= scprb_pkg::RB_CTRL_RESET;
          SW_RESET_O <= 1'b1;
          rb_valid   <= 1'b0;
        end else begin
          if (wr_word.addr == scprb_pkg::RB_CTRL_ADDR) begin
            ctrl <= wr_word.data;
          end
          if (ctrl[scprb_pkg::EN_BIT]) begin
            rb_valid <= 1'b1;
            rb_byte  <= ctrl[scprb_pkg::CONT_BIT] ? live_byte : direct_byte;
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      READBACK_CONTROL_O <= scprb_pkg::RB_CTRL_RESET;
    end else begin
      READBACK_CONTROL_O <= ctrl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three-wire read-back output

  logic [3:0] rb_cnt;
  logic [3:0] next_rb_cnt;

  always_comb begin
    next_rb_cnt = rb_cnt;
    if (csb_fall) begin
      next_rb_cnt = 4'h0;
    end else if (scl_rise && csb_low && rb_cnt < scprb_pkg::RB_BITS) begin
      next_rb_cnt = rb_cnt + 4'h1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rb_cnt                <= scprb_pkg::RB_BITS;
      READBACK_OUT_PIN_O    <= 1'b0;
      READBACK_OUT_PIN_OE_O <= 1'b0;
    end else begin
      rb_cnt                <= next_rb_cnt;
      READBACK_OUT_PIN_O    <= rb_byte[~next_rb_cnt[2:0]] & ~next_rb_cnt[3];
      READBACK_OUT_PIN_OE_O <= SW_CONTROL_O && three_wire && csb_low &&
                               ctrl[scprb_pkg::EN_BIT] && rb_valid &&
                               (next_rb_cnt < scprb_pkg::RB_BITS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  chk_sw_gates_write: assert property (REG_WR_O |-> $past(SW_CONTROL_O))
    else $error("write taken outside software control");
  chk_bus_style_engine: assert property (st != scprb_pkg::TW_IDLE |-> $past(two_wire))
    else $error("two-wire engine active in three-wire mode");
  chk_csb_commit_word: assert property (tw3_wr |=> REG_WR_O &&
    REG_WR_WORD_O == $past(link_word))
    else $error("chip select rise did not commit shifted word");
  chk_sdo_tristate: assert property (!csb_low |=> !READBACK_OUT_PIN_OE_O)
    else $error("read-back driven with chip select high");
  chk_sdo_enable_gate: assert property (READBACK_OUT_PIN_OE_O |->
    $past(ctrl[scprb_pkg::EN_BIT]))
    else $error("read-back driven while disabled");
  chk_cont_status_byte: assert property (wr_req && ctrl[scprb_pkg::EN_BIT] &&
    ctrl[scprb_pkg::CONT_BIT] && wr_word.addr != scprb_pkg::SW_RESET_ADDR
    |=> rb_byte == $past(live_byte))
    else $error("continuous read-back took wrong status byte");
  chk_direct_status_byte: assert property (wr_req && ctrl[scprb_pkg::EN_BIT] &&
    !ctrl[scprb_pkg::CONT_BIT] && stat_hit |=> rb_byte == $past(direct_byte))
    else $error("direct read-back took wrong register");
  chk_soft_reset_ctrl: assert property (REG_WR_O &&
    REG_WR_WORD_O.addr == scprb_pkg::SW_RESET_ADDR |-> SW_RESET_O &&
    ctrl == scprb_pkg::RB_CTRL_RESET)
    else $error("software reset did not restore control");
  chk_start_to_addr: assert property (two_wire && start_det &&
    st == scprb_pkg::TW_IDLE |=> st == scprb_pkg::TW_DEV)
    else $error("start condition not taken");
  chk_ack_matched_only: assert property (st == scprb_pkg::TW_ACK_DEV |->
    sh[7:1] == dev_addr)
    else $error("acknowledge for foreign address");
  chk_mismatch_idle: assert property (two_wire && !start_det && !stop_det &&
    st == scprb_pkg::TW_DEV && scl_rise && bit_cnt == scprb_pkg::BIT_LAST &&
    shift_in[7:1] != dev_addr |=> st == scprb_pkg::TW_IDLE)
    else $error("mismatched address not dropped");
  chk_stop_to_idle: assert property (two_wire && stop_det |=>
    st == scprb_pkg::TW_IDLE && !SERIAL_DATA_PIN_OE_O)
    else $error("stop condition did not idle the engine");
  chk_two_wire_word: assert property (i2c_wr |=> REG_WR_O &&
    REG_WR_WORD_O == $past({hi_byte, sh}))
    else $error("two-wire word assembled wrongly");

  cov_three_wire_write: cover property (tw3_wr ##1 REG_WR_O);
  cov_two_wire_write: cover property (i2c_wr);
  cov_two_wire_read: cover property (st == scprb_pkg::TW_READ ##1 st == scprb_pkg::TW_WAIT_STOP);
  cov_readback_drive: cover property ($rose(READBACK_OUT_PIN_OE_O));
  cov_soft_reset: cover property (SW_RESET_O);

endmodule

`default_nettype wire

// ### testbench/scprb_host.sv
// Host model for the control port: serial clock, data and chip select.
// Assumes device data and enable are fed back; 2-wire data has a pull-up.

`timescale 1ns/1ns
`default_nettype none

module scprb_host (
  // Device outputs
  input  wire logic dev_d_i,
  input  wire logic dev_oe_i,
  input  wire logic rb_i,
  input  wire logic rb_oe_i,
  // Host pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sda_o
);
  localparam int Q = 500;

  logic host_d;

  // Resolved data wire
  assign sda_o = (dev_oe_i ? dev_d_i : 1'b1) & host_d;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    host_d = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // 3-wire frame, read-back sampled mid high phase of rises 1 to 8
  // Undriven read-back pin is seen inverted
  task automatic spi_frame(input logic [15:0] w, output logic [7:0] rb, output logic seen);
    rb = 8'h00;
    seen = 1'b0;
    cs_n_o = 1'b0;
    #60;
    for (int i = 15; i >= 0; i--) begin
      host_d = w[i];
      #15 sclk_o = 1'b1;
      #10;
      if (i >= 8) begin
        rb = {rb[6:0], rb_oe_i ? rb_i : ~rb_i};
        seen = seen | rb_oe_i;
      end
      #5 sclk_o = 1'b0;
    end
    host_d = ~host_d;
    #60 cs_n_o = 1'b1;
    #100;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // 2-wire conditions and bytes
  task automatic tw_start();
    host_d = 1'b1;
    sclk_o = 1'b1;
    #Q host_d = 1'b0;
    #Q sclk_o = 1'b0;
  endtask

  task automatic tw_stop();
    host_d = 1'b0;
    #Q sclk_o = 1'b1;
    #Q host_d = 1'b1;
    #Q;
  endtask

  // Eight bits MSB first then a released ninth bit; r holds the wire samples
  task automatic tw_byte(input logic [7:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      host_d = (i == 0) ? 1'b1 : b[i-1];
      #Q sclk_o = 1'b1;
      #Q r[i] = sda_o;
      #Q sclk_o = 1'b0;
      #Q;
    end
  endtask
endmodule

`default_nettype wire

// ### testbench/scprb_tb.sv
// Testbench for the control port: 3-wire writes and read-back, straps, 2-wire.
// Assumes the host model drives the serial pins; MCLK at 100 MHz.

`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic                 mclk;
  logic                 reset;
  logic                 ctl_strap;
  logic                 bus_strap;
  logic [6:0][7:0]      status;
  logic                 sclk, cs_n, sda, sd_o, sd_oe, rb_pin, rb_oe;
  logic                 reg_wr, sw_reset, sw_ctl, rst_seen, seen;
  logic [8:0]           rbc, r;
  logic [7:0]           rb;
  scprb_pkg::scprb_wr_s wr_word, last_wr;
  int                   wr_cnt = 0;
  int                   n, err_total = 0, comparisons = 0;

  scprb_top dut (
    .MCLK_I(mclk), .RESET_I(reset), .SERIAL_CLK_I(sclk),
    .CONTROL_STYLE_STRAP_I(ctl_strap), .BUS_STYLE_STRAP_I(bus_strap),
    .CHIP_SELECT_N_I(cs_n), .SERIAL_DATA_PIN_I(sda), .SERIAL_DATA_PIN_O(sd_o),
    .SERIAL_DATA_PIN_OE_O(sd_oe), .READBACK_OUT_PIN_O(rb_pin),
    .READBACK_OUT_PIN_OE_O(rb_oe), .STATUS_I(status), .REG_WR_O(reg_wr),
    .REG_WR_WORD_O(wr_word), .SW_RESET_O(sw_reset), .SW_CONTROL_O(sw_ctl),
    .READBACK_CONTROL_O(rbc)
  );

  scprb_host host (
    .dev_d_i(sd_o), .dev_oe_i(sd_oe), .rb_i(rb_pin), .rb_oe_i(rb_oe),
    .sclk_o(sclk), .cs_n_o(cs_n), .sda_o(sda)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Write monitor
  always @(posedge mclk) begin
    if (reg_wr) begin
      wr_cnt <= wr_cnt + 1;
      last_wr <= wr_word;
    end
    if (sw_reset) rst_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] pick(input int s);
    return (s == 7) ? 8'h00 : status[s];
  endfunction

  task automatic wr3(input logic [6:0] a, input logic [8:0] d);
    host.spi_frame({a, d}, rb, seen);
    check("readback idle", {15'h0, rb_oe}, 16'h0);
  endtask

  task automatic tw_wr(input logic [6:0] dev, input logic [6:0] a, input logic [8:0] d,
                       input logic nak);
    host.tw_start();
    host.tw_byte({dev, 1'b0}, r);
    check("address ack", {15'h0, r[0]}, {15'h0, nak});
    if (!nak) begin
      host.tw_byte({a, d[8]}, r);
      check("first ack", {15'h0, r[0]}, 16'h0);
      host.tw_byte(d[7:0], r);
      check("second ack", {15'h0, r[0]}, 16'h0);
    end
    host.tw_stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    err_total++;
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    ctl_strap = 1'b0;
    bus_strap = 1'b1;
    rst_seen = 1'b0;
    status = {8'h71, 8'h62, 8'hc5, 8'h9a, 8'h4e, 8'h17, 8'hb3};
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    check("software control", {15'h0, sw_ctl}, 16'h1);
    check("control reset", {7'h0, rbc}, 16'h0);
    wr3(7'h12, 9'h1a5);
    check("write word", last_wr, {7'h12, 9'h1a5});
    for (int k = 0; k < 10; k++) begin
      wr3(7'h34, {4'h0, 2'b11, k[2:0]});
      check("control value", {7'h0, rbc}, {7'h0, 4'h0, 2'b11, k[2:0]});
      check("readback drive", {15'h0, seen}, {15'h0, k >= 2});
      if (k >= 2) check("readback byte", {8'h0, rb}, {8'h0, pick(k - 2)});
    end
    wr3(7'h34, 9'h010);
    wr3(7'h3a, 9'h000);
    wr3(7'h7f, 9'h000);
    check("direct byte", {8'h0, rb}, {8'h0, status[2]});
    wr3(7'h34, 9'h000);
    check("direct other", {8'h0, rb}, 16'h0);
    wr3(7'h12, 9'h000);
    wr3(7'h12, 9'h000);
    check("disabled drive", {15'h0, seen}, 16'h0);
    wr3(7'h34, 9'h01b);
    wr3(7'h35, 9'h0ab);
    check("reset pulse", {15'h0, rst_seen}, 16'h1);
    check("reset control", {7'h0, rbc}, 16'h0);
    wr3(7'h12, 9'h000);
    check("reset latch", {15'h0, seen}, 16'h0);
    @(posedge mclk);
    ctl_strap <= 1'b1;
    repeat (8) @(posedge mclk);
    check("hardware mode", {15'h0, sw_ctl}, 16'h0);
    n = wr_cnt;
    wr3(7'h12, 9'h0ff);
    check("hardware write", 16'(wr_cnt - n), 16'h0);
    @(posedge mclk);
    ctl_strap <= 1'b0;
    bus_strap <= 1'b0;
    repeat (8) @(posedge mclk);
    wr3(7'h12, 9'h0ff);
    check("three-wire ignored", 16'(wr_cnt - n), 16'h0);
    host.cs_n_o = 1'b0;
    tw_wr(7'h1a, 7'h34, 9'h01d, 1'b0);
    check("two-wire word", last_wr, {7'h34, 9'h01d});
    check("two-wire control", {7'h0, rbc}, 16'h01d);
    host.tw_start();
    host.tw_byte({7'h1a, 1'b1}, r);
    host.tw_byte(8'hff, r);
    check("two-wire read", {8'h0, r[8:1]}, {8'h0, status[5]});
    host.tw_stop();
    n = wr_cnt;
    tw_wr(7'h1b, 7'h12, 9'h000, 1'b1);
    host.tw_start();
    host.tw_byte({7'h1a, 1'b0}, r);
    host.tw_byte({7'h12, 1'b1}, r);
    host.tw_stop();
    check("dropped writes", 16'(wr_cnt - n), 16'h0);
    host.cs_n_o = 1'b1;
    tw_wr(7'h1b, 7'h12, 9'h155, 1'b0);
    check("alternate address", last_wr, {7'h12, 9'h155});
    tw_wr(7'h1b, 7'h34, 9'h010, 1'b0);
    tw_wr(7'h1b, 7'h3c, 9'h000, 1'b0);
    host.tw_start();
    host.tw_byte({7'h1b, 1'b1}, r);
    host.tw_byte(8'hff, r);
    check("two-wire direct", {8'h0, r[8:1]}, {8'h0, status[4]});
    host.tw_stop();
    report_and_stop();
  end
endmodule

`default_nettype wire
